// ==== core/monitor_control_data_regs.sv ====
// Control and data register bank of the analog monitor and controller.
// Assumes a serial-bus front end giving one-cycle read and write strobes.
`timescale 1ns/1ps
module monitor_control_data_regs (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  output logic      [15:0]         reg_rdata,
  input  wire logic                continuous_run,
  input  wire logic                register_lock,
  input  wire logic                res_wr,
  input  wire logic [3:0]          res_ch,
  input  wire logic [11:0]         res_data,
  input  wire logic [5:0]          high_flag,
  input  wire logic [5:0]          low_flag,
  input  wire logic [3:0]          output_override,
  output logic      [5:0]          high_limit_irq_enable,
  output logic      [5:0]          low_limit_irq_enable,
  output logic      [7:0]          conv_enable_low_channels,
  output logic      [7:0]          conv_enable_high_channels,
  output logic                     temperature_channel_enable,
  output logic                     one_pass_request,
  output logic                     conversion_running,
  output logic                     converter_in_ref_external,
  output logic                     converter_out_ref_select,
  output logic                     ref_reserved_bit,
  output logic [5:0][11:0]         window_upper_threshold,
  output logic [5:0][11:0]         window_lower_threshold,
  output logic [11:0][11:0]        analog_output_voltage,
  output logic [11:0]              code_update,
  output logic [11:0][11:0]        analog_output_pin,
  output logic                     interrupt_line_one,
  output logic                     interrupt_line_two
);

  logic [11:0] result_r [16];
  logic [15:0] rdata_nxt;
  logic [3:0]  page;
  logic [3:0]  idx;
  logic        wr_ctl;
  logic        irq_nxt;

  assign page    = reg_addr[7:4];
  assign idx     = reg_addr[3:0];
  assign wr_ctl  = reg_wr && !register_lock;
  assign irq_nxt = |(high_flag & high_limit_irq_enable)
                 | |(low_flag & low_limit_irq_enable);

  // Interrupt enables
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      high_limit_irq_enable <= monitor_regs_pkg::IRQ_EN_RST;
      low_limit_irq_enable  <= monitor_regs_pkg::IRQ_EN_RST;
    end else if (wr_ctl) begin
      if (reg_addr == monitor_regs_pkg::OFS_HI_IRQ_EN) begin
        high_limit_irq_enable <= reg_wdata[5:0];
      end
      if (reg_addr == monitor_regs_pkg::OFS_LO_IRQ_EN) begin
        low_limit_irq_enable <= reg_wdata[5:0];
      end
    end
  end

  // Conversion enables
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      conv_enable_low_channels   <= monitor_regs_pkg::CONV_EN_RST;
      conv_enable_high_channels  <= monitor_regs_pkg::CONV_EN_RST;
      temperature_channel_enable <= 1'b0;
    end else if (wr_ctl) begin
      if (reg_addr == monitor_regs_pkg::OFS_CONV_LOW) begin
        conv_enable_low_channels <= reg_wdata[7:0];
      end
      if (reg_addr == monitor_regs_pkg::OFS_CONV_HIGH) begin
        conv_enable_high_channels <= reg_wdata[7:0];
      end
      if (reg_addr == monitor_regs_pkg::OFS_CONV_TEMP) begin
        temperature_channel_enable <= reg_wdata[0];
      end
    end
  end

  // Reference selection
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      converter_in_ref_external <= monitor_regs_pkg::REF_SEL_RST[2];
      converter_out_ref_select  <= monitor_regs_pkg::REF_SEL_RST[1];
      ref_reserved_bit          <= monitor_regs_pkg::REF_SEL_RST[0];
    end else if (wr_ctl && reg_addr == monitor_regs_pkg::OFS_REF_SEL) begin
      converter_in_ref_external <= reg_wdata[monitor_regs_pkg::REF_ADC_BIT];
      converter_out_ref_select  <= reg_wdata[monitor_regs_pkg::REF_DAC_BIT];
      ref_reserved_bit          <= reg_wdata[0];
    end
  end

  // Sequencer start controls
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      one_pass_request   <= 1'b0;
      conversion_running <= 1'b0;
    end else begin
      one_pass_request   <= reg_wr && reg_addr == monitor_regs_pkg::OFS_TRIGGER
                            && !continuous_run && register_lock;
      conversion_running <= continuous_run && register_lock;
    end
  end

  // Conversion results, written only by the sequencer
  generate
    for (genvar r = 0; r < monitor_regs_pkg::NUM_RESULT; r++) begin : g_result
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          result_r[r] <= monitor_regs_pkg::RESULT_RST;
        end else if (res_wr && res_ch == 4'(r)) begin
          result_r[r] <= res_data;
        end
      end
    end
  endgenerate

  // Window thresholds
  generate
    for (genvar l = 0; l < monitor_regs_pkg::NUM_LIMIT; l++) begin : g_limit
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          window_upper_threshold[l] <= monitor_regs_pkg::UPPER_RST;
          window_lower_threshold[l] <= monitor_regs_pkg::LOWER_RST;
        end else if (wr_ctl && idx == 4'(l)) begin
          if (page == monitor_regs_pkg::PAGE_UPPER) begin
            window_upper_threshold[l] <= reg_wdata[11:0];
          end
          if (page == monitor_regs_pkg::PAGE_LOWER) begin
            window_lower_threshold[l] <= reg_wdata[11:0];
          end
        end
      end
    end
  endgenerate

  // Output codes and pin drive
  generate
    for (genvar c = 0; c < monitor_regs_pkg::NUM_CODE; c++) begin : g_code
      logic code_wr;
      assign code_wr = reg_wr && page == monitor_regs_pkg::PAGE_CODE && idx == 4'(c);
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          analog_output_voltage[c] <= monitor_regs_pkg::CODE_RST;
          code_update[c]           <= 1'b0;
        end else begin
          code_update[c] <= code_wr;
          if (code_wr) begin
            analog_output_voltage[c] <= reg_wdata[11:0];
          end
        end
      end
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          analog_output_pin[c] <= monitor_regs_pkg::CODE_RST;
        end else if (!output_override[c / monitor_regs_pkg::CODES_PER_OVR]) begin
          analog_output_pin[c] <= analog_output_voltage[c];
        end
      end
    end
  endgenerate

  // Interrupt outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_line_one <= 1'b0;
      interrupt_line_two <= 1'b0;
    end else begin
      interrupt_line_one <= irq_nxt;
      interrupt_line_two <= irq_nxt;
    end
  end

  // Read decode; reads touch no sequencer state
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (page)
      4'h0: begin
        unique case (reg_addr)
          monitor_regs_pkg::OFS_HI_IRQ_EN: rdata_nxt[5:0] = high_limit_irq_enable;
          monitor_regs_pkg::OFS_LO_IRQ_EN: rdata_nxt[5:0] = low_limit_irq_enable;
          monitor_regs_pkg::OFS_CONV_LOW:  rdata_nxt[7:0] = conv_enable_low_channels;
          monitor_regs_pkg::OFS_CONV_HIGH: rdata_nxt[7:0] = conv_enable_high_channels;
          monitor_regs_pkg::OFS_CONV_TEMP: rdata_nxt[0]   = temperature_channel_enable;
          monitor_regs_pkg::OFS_REF_SEL:   rdata_nxt[2:0] = {converter_in_ref_external,
                                                   converter_out_ref_select,
                                                   ref_reserved_bit};
          default:                         rdata_nxt = 16'h0000;
        endcase
      end
      monitor_regs_pkg::PAGE_RESULT: rdata_nxt[11:0] = result_r[idx];
      monitor_regs_pkg::PAGE_UPPER: begin
        if (idx < 4'h6) begin
          rdata_nxt[11:0] = window_upper_threshold[idx[2:0]];
        end
      end
      monitor_regs_pkg::PAGE_LOWER: begin
        if (idx < 4'h6) begin
          rdata_nxt[11:0] = window_lower_threshold[idx[2:0]];
        end
      end
      monitor_regs_pkg::PAGE_CODE: begin
        if (idx < 4'hC) begin
          rdata_nxt[11:0] = analog_output_voltage[idx];
        end
      end
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_trigger_starts_pass: assert property (
    reg_wr && reg_addr == monitor_regs_pkg::OFS_TRIGGER && !continuous_run && register_lock
    |=> one_pass_request)
    else $error("trigger write did not start a pass");

  a_trigger_needs_lock: assert property (
    !register_lock |=> !one_pass_request)
    else $error("pass started without lock");

  a_trigger_blocked_run: assert property (
    continuous_run |=> !one_pass_request)
    else $error("pass started during continuous run");

  a_run_follows_lock: assert property (
    ##1 conversion_running == $past(continuous_run && register_lock))
    else $error("continuous run not gated by lock");

  a_lock_holds_enables: assert property (
    register_lock && reg_wr
    |=> $stable(conv_enable_low_channels) && $stable(window_upper_threshold))
    else $error("locked register changed on write");

  a_code_write_lands: assert property (
    reg_wr && reg_addr == {monitor_regs_pkg::PAGE_CODE, 4'h0}
    |=> analog_output_voltage[0] == $past(reg_wdata[11:0]) && code_update[0])
    else $error("output code write lost");

  a_read_upper_zero: assert property (
    reg_rdata[15:12] == 4'h0)
    else $error("upper read bits not zero");

  a_pin_held_override: assert property (
    output_override[0] |=> $stable(analog_output_pin[0]))
    else $error("pin followed code while overridden");

  a_result_kept_enable: assert property (
    reg_wr && reg_addr == monitor_regs_pkg::OFS_CONV_LOW && !res_wr
    |=> $stable(result_r[0]))
    else $error("result changed by enable write");

  a_irq_from_flags: assert property (
    (|(high_flag & high_limit_irq_enable)) |=> interrupt_line_one)
    else $error("enabled high flag gave no interrupt");

  a_hi_enable_lands: assert property (
    reg_wr && !register_lock && reg_addr == monitor_regs_pkg::OFS_HI_IRQ_EN
    |=> high_limit_irq_enable == $past(reg_wdata[5:0]))
    else $error("high irq enable write lost");

  a_lo_enable_lands: assert property (
    reg_wr && !register_lock && reg_addr == monitor_regs_pkg::OFS_LO_IRQ_EN
    |=> low_limit_irq_enable == $past(reg_wdata[5:0]))
    else $error("low irq enable write lost");

  a_conv_low_lands: assert property (
    reg_wr && !register_lock && reg_addr == monitor_regs_pkg::OFS_CONV_LOW
    |=> conv_enable_low_channels == $past(reg_wdata[7:0]))
    else $error("low channel enable write lost");

  a_conv_high_lands: assert property (
    reg_wr && !register_lock && reg_addr == monitor_regs_pkg::OFS_CONV_HIGH
    |=> conv_enable_high_channels == $past(reg_wdata[7:0]))
    else $error("high channel enable write lost");

  a_temp_enable_lands: assert property (
    reg_wr && !register_lock && reg_addr == monitor_regs_pkg::OFS_CONV_TEMP
    |=> temperature_channel_enable == $past(reg_wdata[0]))
    else $error("temperature enable write lost");

  a_ref_adc_bit: assert property (
    reg_wr && !register_lock && reg_addr == monitor_regs_pkg::OFS_REF_SEL
    |=> converter_in_ref_external == $past(reg_wdata[monitor_regs_pkg::REF_ADC_BIT]))
    else $error("converter-in reference bit wrong");

  a_ref_dac_bit: assert property (
    reg_wr && !register_lock && reg_addr == monitor_regs_pkg::OFS_REF_SEL
    |=> converter_out_ref_select == $past(reg_wdata[monitor_regs_pkg::REF_DAC_BIT]))
    else $error("converter-out reference bit wrong");

  a_ref_reserved_kept: assert property (
    reg_wr && !register_lock && reg_addr == monitor_regs_pkg::OFS_REF_SEL
    |=> ref_reserved_bit == $past(reg_wdata[0]))
    else $error("reserved reference bit not stored");

  a_upper_write_lands: assert property (
    reg_wr && !register_lock && reg_addr == {monitor_regs_pkg::PAGE_UPPER, 4'h5}
    |=> window_upper_threshold[5] == $past(reg_wdata[11:0]))
    else $error("upper threshold write lost");

  a_lower_write_lands: assert property (
    reg_wr && !register_lock && reg_addr == {monitor_regs_pkg::PAGE_LOWER, 4'h0}
    |=> window_lower_threshold[0] == $past(reg_wdata[11:0]))
    else $error("lower threshold write lost");

  a_lock_holds_limits: assert property (
    register_lock && reg_wr
    |=> $stable(window_lower_threshold) && $stable(high_limit_irq_enable)
        && $stable(converter_in_ref_external) && $stable(temperature_channel_enable))
    else $error("locked limit or control register changed on write");

  a_result_write_lands: assert property (
    res_wr && res_ch == 4'h3
    |=> result_r[3] == $past(res_data))
    else $error("result write lost");

  a_result_kept_read: assert property (
    !res_wr |=> $stable(result_r[7]))
    else $error("result changed without sequencer write");

  a_pin_follows_code: assert property (
    !output_override[3]
    |=> analog_output_pin[11] == $past(analog_output_voltage[11]))
    else $error("pin did not follow code");

  a_pass_needs_write: assert property (
    !(reg_wr && reg_addr == monitor_regs_pkg::OFS_TRIGGER) |=> !one_pass_request)
    else $error("pass started without trigger write");

  a_irq_from_low: assert property (
    (|(low_flag & low_limit_irq_enable)) |=> interrupt_line_two)
    else $error("enabled low flag gave no interrupt");

  a_irq_quiet_idle: assert property (
    !(|(high_flag & high_limit_irq_enable)) && !(|(low_flag & low_limit_irq_enable))
    |=> !interrupt_line_one && !interrupt_line_two)
    else $error("interrupt raised with no enabled flag");

  c_one_pass: cover property (register_lock ##1 one_pass_request);
  c_run_start: cover property (!conversion_running ##1 conversion_running);
  c_code_overridden: cover property (output_override[0] && code_update[0]);
  c_irq_raised: cover property (!interrupt_line_one ##1 interrupt_line_one);

endmodule // monitor_control_data_regs

// ==== pkg/monitor_regs_pkg.sv ====
// Constants for the monitor control and data register bank.
// Assumes an 8-bit register address and 16-bit data from the serial port.
package monitor_regs_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  localparam int          CODE_W        = 12;
  localparam int          NUM_RESULT    = 16;
  localparam int          NUM_LIMIT     = 6;
  localparam int          NUM_CODE      = 12;
  localparam int          NUM_OVERRIDE  = 4;
  localparam int          CODES_PER_OVR = 3;
  localparam logic [7:0]  OFS_HI_IRQ_EN = 8'h00;
  localparam logic [7:0]  OFS_LO_IRQ_EN = 8'h01;
  localparam logic [7:0]  OFS_CONV_LOW  = 8'h02;
  localparam logic [7:0]  OFS_CONV_HIGH = 8'h03;
  localparam logic [7:0]  OFS_CONV_TEMP = 8'h04;
  localparam logic [7:0]  OFS_TRIGGER   = 8'h05;
  localparam logic [7:0]  OFS_REF_SEL   = 8'h06;
  localparam logic [3:0]  PAGE_RESULT   = 4'h2;
  localparam logic [3:0]  PAGE_UPPER    = 4'h3;
  localparam logic [3:0]  PAGE_LOWER    = 4'h4;
  localparam logic [3:0]  PAGE_CODE     = 4'h5;
  localparam logic [5:0]  IRQ_EN_RST    = 6'h00;
  localparam logic [7:0]  CONV_EN_RST   = 8'h00;
  localparam logic [2:0]  REF_SEL_RST   = 3'h7;
  localparam int          REF_ADC_BIT   = 2;
  localparam int          REF_DAC_BIT   = 1;
  localparam logic [11:0] RESULT_RST    = 12'h000;
  localparam logic [11:0] UPPER_RST     = 12'hFFF;
  localparam logic [11:0] LOWER_RST     = 12'h000;
  localparam logic [11:0] CODE_RST      = 12'h000;
endpackage

// ==== testbench/host_model.sv ====
// Host model: issues register writes and reads on the strobe bus.
// Assumes read data is registered and valid just after the edge taking the read.
`timescale 1ns/1ps
module host_model (
  input  wire logic        clock,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 16'h0000;
  end

  // Whole 16-bit word per access; idle lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d | {15'h0000, a == monitor_regs_pkg::OFS_REF_SEL};
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    q = reg_rdata;
  endtask
endmodule // host_model

// ==== testbench/tb.sv ====
// Self-checking bench for the monitor register bank.
// Assumes the host model drives the register bus; sequencer inputs come from here.
`timescale 1ns/1ps
module tb;
  logic              clock = 1'b0;
  logic              sys_rst = 1'b1;
  logic              reg_wr, reg_rd;
  logic [7:0]        reg_addr, a;
  logic [15:0]       reg_wdata, reg_rdata, q, d;
  logic              continuous_run = 1'b0;
  logic              register_lock = 1'b0;
  logic              res_wr = 1'b0;
  logic [3:0]        res_ch = 4'h0;
  logic [11:0]       res_data = 12'h000;
  logic [5:0]        high_flag = 6'h00;
  logic [5:0]        low_flag = 6'h00;
  logic [3:0]        output_override = 4'h0;
  logic [5:0]        hi_en, lo_en;
  logic [7:0]        conv_lo, conv_hi;
  logic              temp_en, one_pass, running, ref_ext, ref_out, ref_rsv, irq_one, irq_two;
  logic [5:0][11:0]  upper, lower;
  logic [11:0][11:0] voltage, pin;
  logic [11:0]       code_upd;
  logic [15:0]       mdl [0:255];
  logic [11:0]       res_mdl [0:15];
  logic [7:0]        lk [0:8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h35, 8'h40, 8'h5B};
  integer            seed = 6;
  integer            bad_count = 0;
  integer            tests_run = 0;

  host_model host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  monitor_control_data_regs dut (
    .clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .continuous_run,
    .register_lock, .res_wr, .res_ch, .res_data, .high_flag, .low_flag, .output_override,
    .high_limit_irq_enable(hi_en), .low_limit_irq_enable(lo_en),
    .conv_enable_low_channels(conv_lo), .conv_enable_high_channels(conv_hi),
    .temperature_channel_enable(temp_en), .one_pass_request(one_pass),
    .conversion_running(running), .converter_in_ref_external(ref_ext),
    .converter_out_ref_select(ref_out), .ref_reserved_bit(ref_rsv),
    .window_upper_threshold(upper), .window_lower_threshold(lower),
    .analog_output_voltage(voltage), .code_update(code_upd), .analog_output_pin(pin),
    .interrupt_line_one(irq_one), .interrupt_line_two(irq_two));

  always #25 clock = ~clock;

  task check(input logic [15:0] got, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task conclude;
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Bits kept at each address; zero where nothing is writable
  function automatic logic [15:0] msk(input logic [7:0] x);
    if (x <= 8'h01) return 16'h003F;
    if (x <= 8'h03) return 16'h00FF;
    if (x == monitor_regs_pkg::OFS_CONV_TEMP) return 16'h0001;
    if (x == monitor_regs_pkg::OFS_REF_SEL) return 16'h0007;
    if (x[7:4] == monitor_regs_pkg::PAGE_UPPER && x[3:0] < 4'h6) return 16'h0FFF;
    if (x[7:4] == monitor_regs_pkg::PAGE_LOWER && x[3:0] < 4'h6) return 16'h0FFF;
    if (x[7:4] == monitor_regs_pkg::PAGE_CODE && x[3:0] < 4'hC) return 16'h0FFF;
    return 16'h0000;
  endfunction

  task put(input logic [7:0] x, input logic [15:0] v);
    host.wr(x, v);
    if (msk(x) != 16'h0000 && (!register_lock || x[7:4] == monitor_regs_pkg::PAGE_CODE))
      mdl[x] = (v | {15'h0000, x == monitor_regs_pkg::OFS_REF_SEL}) & msk(x);
  endtask

  task vfy(input logic [7:0] x);
    host.rd(x, q);
    check(q, mdl[x]);
  endtask

  initial begin
    #500000;
    bad_count = bad_count + 1;
    conclude;
  end

  initial begin
    for (int i = 0; i < 256; i++) mdl[i] = (i >= 8'h30 && i < 8'h36) ? 16'h0FFF : 16'h0000;
    for (int i = 0; i < 16; i++) res_mdl[i] = 12'h000;
    mdl[8'h06] = 16'h0007;
    repeat (3) @(posedge clock);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 8'h60; i++) vfy(8'(i));
    // Random writes with readback on pages 0, 1, 4 and 5, unmapped places among them
    for (int i = 0; i < 80; i++) begin
      a = 8'($random(seed)) & 8'h5F;
      put(a, 16'($random(seed)));
      vfy(a);
    end
    // Corner case: all ones written to every kind of register except the trigger and the results
    for (int i = 0; i < 9; i++) begin
      put(lk[i], 16'hFFFF);
      vfy(lk[i]);
    end
    for (int i = 0; i < 12; i++) begin
      check({4'h0, voltage[i]}, mdl[8'h50 + i]);
      if (i < 6) check({4'h0, upper[i]}, mdl[8'h30 + i]);
      if (i < 6) check({4'h0, lower[i]}, mdl[8'h40 + i]);
    end
    check({2'h0, hi_en, 2'h0, lo_en}, {mdl[0][7:0], mdl[1][7:0]});
    check({conv_hi, conv_lo}, {mdl[3][7:0], mdl[2][7:0]});
    check({12'h000, temp_en, ref_ext, ref_out, ref_rsv}, {12'h000, mdl[4][0], mdl[6][2:0]});
    for (int j = 0; j < 4; j++) begin
      put(monitor_regs_pkg::OFS_REF_SEL, 16'(j * 2));
      check({14'h0000, ref_ext, ref_out}, 16'(j));
    end
    // Locked: lockable places keep contents, codes still take writes
    register_lock = 1'b1;
    for (int i = 0; i < 9; i++) begin
      put(lk[i], 16'($random(seed)));
      vfy(lk[i]);
    end
    // Trigger under every run and lock combination; lock comes first
    for (int j = 0; j < 4; j++) begin
      {register_lock, continuous_run} = 2'(j);
      put(monitor_regs_pkg::OFS_TRIGGER, 16'($random(seed)));
      check({15'h0000, one_pass}, {15'h0000, register_lock & ~continuous_run});
      check({15'h0000, running}, {15'h0000, register_lock & continuous_run});
      @(posedge clock);
      #1;
      check({15'h0000, one_pass}, 16'h0000);
    end
    {register_lock, continuous_run} = 2'b00;
    // Results written while the previous one is read
    for (int i = 0; i < 16; i++) begin
      res_mdl[i] = 12'($random(seed));
      fork
        host.rd(8'h20 + 8'((i + 15) % 16), q);
        begin
          @(posedge clock);
          #1;
          res_wr = 1'b1;
          res_ch = 4'(i);
          res_data = res_mdl[i];
          @(posedge clock);
          #1;
          res_wr = 1'b0;
          res_data = ~res_data;
        end
      join
      check(q, {4'h0, res_mdl[(i + 15) % 16]});
    end
    put(monitor_regs_pkg::OFS_CONV_LOW, 16'($random(seed)));
    put(monitor_regs_pkg::OFS_CONV_TEMP, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      host.rd(8'h20 + 8'(i), q);
      check(q, {4'h0, res_mdl[i]});
    end
    // Code written while its output group is overridden
    output_override = 4'h1;
    d = {4'hA, ~mdl[8'h50][11:0]};
    put(8'h50, d);
    check({4'h0, code_upd}, 16'h0001);
    @(posedge clock);
    #1;
    check({4'h0, voltage[0]}, {4'h0, d[11:0]});
    check({4'h0, pin[0]}, {4'h0, ~d[11:0]});
    output_override = 4'h0;
    repeat (2) @(posedge clock);
    #1;
    check({4'h0, pin[0]}, {4'h0, d[11:0]});
    for (int i = 1; i < 12; i++) check({4'h0, pin[i]}, mdl[8'h50 + i]);
    // Interrupt from random flags and enables
    for (int i = 0; i < 12; i++) begin
      put(monitor_regs_pkg::OFS_HI_IRQ_EN, 16'($random(seed)));
      put(monitor_regs_pkg::OFS_LO_IRQ_EN, 16'($random(seed)));
      high_flag = 6'($random(seed));
      low_flag = 6'($random(seed));
      @(posedge clock);
      #1;
      check({14'h0000, irq_one, irq_two},
            {14'h0000, {2{|(high_flag & mdl[0][5:0]) | |(low_flag & mdl[1][5:0])}}});
    end
    conclude;
  end
endmodule // tb
